// [tlc_timer.sv]
// low timer of a timer pair with its control fields, chaining to the upper timer
//
// The address map and strobed register access were decided locally.
`timescale 1ns/10ps
module tlc_timer
	import tlc_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        reset_n,
	input  wire logic        idle_mode,
	input  wire logic        gate_in,
	input  wire logic        ext_count_pin,
	input  wire logic        high_gate_in,
	input  wire logic [3:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic [15:0]      rdata,
	output logic             irq,
	output logic             low_match,
	output logic             high_match
);
	logic [15:0] ctrl_reg;
	logic [15:0] hctrl_reg;
	logic [15:0] low_count_reg;
	logic [15:0] high_count_reg;
	logic [15:0] low_period_reg;
	logic [15:0] high_period_reg;
	logic [1:0]  status_reg;
	logic [1:0]  mask_reg;
	logic [15:0] rdata_reg;
	logic        irq_reg;
	logic        low_match_reg;
	logic        high_match_reg;
	tlc_ctrl_t   lc;
	tlc_ctrl_t   hc;
	logic        gate_s;
	logic        hgate_s;
	logic        ext_rise;
	logic        low_active;
	logic        high_active;
	logic        low_src;
	logic        high_src;
	logic        low_tick;
	logic        high_tick;
	logic        low_hit;
	logic        high_hit;
	logic        chain_hit;
	logic [1:0]  ev;
	logic [1:0]  status_next;
	logic [1:0]  mask_next;

	assign lc = tlc_decode(ctrl_reg);
	assign hc = tlc_decode(hctrl_reg);

	tlc_sync u_gate_sync (
		.mclk    (mclk),
		.reset_n (reset_n),
		.din     (gate_in),
		.level   (gate_s),
		.rise    ()
	);

	tlc_sync u_hgate_sync (
		.mclk    (mclk),
		.reset_n (reset_n),
		.din     (high_gate_in),
		.level   (hgate_s),
		.rise    ()
	);

	tlc_sync u_ext_sync (
		.mclk    (mclk),
		.reset_n (reset_n),
		.din     (ext_count_pin),
		.level   (),
		.rise    (ext_rise)
	);

	// idle halts only when idle_stop is set
	assign low_active  = lc.run && !(idle_mode && lc.idle_stop);
	assign high_active = hc.run && !(idle_mode && hc.idle_stop);

	// low timer external edges ignore the gate, upper timer running alone counts nothing on external select; internal clock may be gated
	always_comb begin
		if (lc.csrc)
			low_src = ext_rise;
		else
			low_src = !lc.gate_en || gate_s;
		if (hc.csrc)
			high_src = 1'b0;
		else
			high_src = !hc.gate_en || hgate_s;
	end

	tlc_prescale u_low_ps (
		.mclk     (mclk),
		.reset_n  (reset_n),
		.clear    (!low_active),
		.tick_in  (low_src && low_active),
		.sel      (lc.prescale),
		.tick_out (low_tick)
	);

	// upper prescaler only serves the upper timer when running alone
	tlc_prescale u_high_ps (
		.mclk     (mclk),
		.reset_n  (reset_n),
		.clear    (!high_active || lc.chain),
		.tick_in  (high_src && high_active && !lc.chain),
		.sel      (hc.prescale),
		.tick_out (high_tick)
	);

	assign low_hit   = low_count_reg == low_period_reg;
	assign high_hit  = high_count_reg == high_period_reg;
	assign chain_hit = low_hit && high_hit;

	// counters; a software write to a count register wins over a tick
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			low_count_reg  <= 16'h0000;
			high_count_reg <= 16'h0000;
		end else begin
			if (wr && addr == TLC_OFS_LOW_CNT)
				low_count_reg <= wdata;
			else if (low_tick) begin
				if (lc.chain ? chain_hit : low_hit)
					low_count_reg <= 16'h0000;
				else
					low_count_reg <= low_count_reg + 16'h0001;
			end
			if (wr && addr == TLC_OFS_HIGH_CNT)
				high_count_reg <= wdata;
			else if (lc.chain && low_tick) begin
				if (chain_hit)
					high_count_reg <= 16'h0000;
				else if (low_count_reg == 16'hFFFF)
					high_count_reg <= high_count_reg + 16'h0001;
			end else if (!lc.chain && high_tick) begin
				if (high_hit)
					high_count_reg <= 16'h0000;
				else
					high_count_reg <= high_count_reg + 16'h0001;
			end
		end
	end

	// chained match reports through the upper flag only
	always_comb begin
		ev = 2'b00;
		if (lc.chain)
			ev[TLC_ST_HIGH] = low_tick && chain_hit;
		else begin
			ev[TLC_ST_LOW]  = low_tick && low_hit;
			ev[TLC_ST_HIGH] = high_tick && high_hit;
		end
	end

	// set wins over a write-one-to-clear in the same cycle
	always_comb begin
		status_next = status_reg;
		if (wr && addr == TLC_OFS_STATUS)
			status_next = status_reg & ~wdata[1:0];
		status_next = status_next | ev;
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			status_reg <= 2'b00;
		else
			status_reg <= status_next;
	end

	// a mask write counts in its own cycle, so irq never lags a freshly unmasked bit
	always_comb begin
		mask_next = mask_reg;
		if (wr && addr == TLC_OFS_MASK)
			mask_next = wdata[1:0];
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_reg        <= TLC_CTRL_RESET;
			hctrl_reg       <= TLC_CTRL_RESET;
			low_period_reg  <= TLC_PER_RESET;
			high_period_reg <= TLC_PER_RESET;
			mask_reg        <= 2'b00;
		end else if (wr) begin
			case (addr)
				TLC_OFS_CTRL:      ctrl_reg <= wdata & TLC_CTRL_WMASK;
				TLC_OFS_HIGH_CTRL: hctrl_reg <= wdata & TLC_HCTRL_WMASK;
				TLC_OFS_LOW_PER:   low_period_reg <= wdata;
				TLC_OFS_HIGH_PER:  high_period_reg <= wdata;
				TLC_OFS_MASK:      mask_reg <= wdata[1:0];
				default:           ;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			rdata_reg <= 16'h0000;
		else if (rd) begin
			case (addr)
				TLC_OFS_CTRL:      rdata_reg <= ctrl_reg;
				TLC_OFS_HIGH_CTRL: rdata_reg <= hctrl_reg;
				TLC_OFS_LOW_CNT:   rdata_reg <= low_count_reg;
				TLC_OFS_HIGH_CNT:  rdata_reg <= high_count_reg;
				TLC_OFS_LOW_PER:   rdata_reg <= low_period_reg;
				TLC_OFS_HIGH_PER:  rdata_reg <= high_period_reg;
				TLC_OFS_STATUS:    rdata_reg <= {14'h0, status_reg};
				TLC_OFS_MASK:      rdata_reg <= {14'h0, mask_reg};
				default:           rdata_reg <= 16'h0000;
			endcase
		end else
			rdata_reg <= 16'h0000;
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			irq_reg        <= 1'b0;
			low_match_reg  <= 1'b0;
			high_match_reg <= 1'b0;
		end else begin
			irq_reg        <= |(status_next & mask_next);
			low_match_reg  <= ev[TLC_ST_LOW];
			high_match_reg <= ev[TLC_ST_HIGH];
		end
	end

	assign rdata      = rdata_reg;
	assign irq        = irq_reg;
	assign low_match  = low_match_reg;
	assign high_match = high_match_reg;

	property p_idle_hold;
		@(posedge mclk) disable iff (!reset_n)
		(idle_mode && lc.idle_stop && !wr) |=> $stable(low_count_reg);
	endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("low count moved while stopped in idle");

	property p_ext_ignores_gate;
		@(posedge mclk) disable iff (!reset_n)
		(lc.csrc && lc.run && !idle_mode && lc.prescale == 2'h0 && ext_rise) |-> low_tick;
	endproperty
	a_ext_ignores_gate: assert property (p_ext_ignores_gate) else $error("external edge lost to gate");

	property p_gate_blocks;
		@(posedge mclk) disable iff (!reset_n)
		(!lc.csrc && lc.gate_en && !gate_s) |-> !low_tick;
	endproperty
	a_gate_blocks: assert property (p_gate_blocks) else $error("tick while gate low");

	property p_div8;
		@(posedge mclk) disable iff (!reset_n)
		(low_tick && lc.prescale == 2'h1) |=> !low_tick [*7];
	endproperty
	a_div8: assert property (p_div8) else $error("1:8 prescale ticked early");

	property p_div1;
		@(posedge mclk) disable iff (!reset_n)
		(low_active && !lc.csrc && !lc.gate_en && lc.prescale == 2'h0 && $stable(ctrl_reg)) |-> low_tick;
	endproperty
	a_div1: assert property (p_div1) else $error("1:1 prescale missed a cycle");

	property p_chain_carry;
		@(posedge mclk) disable iff (!reset_n)
		(lc.chain && low_tick && !chain_hit && low_count_reg == 16'hFFFF && !wr)
			|=> (high_count_reg == $past(high_count_reg) + 16'h0001 && low_count_reg == 16'h0000);
	endproperty
	a_chain_carry: assert property (p_chain_carry) else $error("32-bit carry wrong");

	property p_chain_flag;
		@(posedge mclk) disable iff (!reset_n)
		lc.chain |-> !ev[TLC_ST_LOW];
	endproperty
	a_chain_flag: assert property (p_chain_flag) else $error("low flag raised in 32-bit mode");

	property p_run_off;
		@(posedge mclk) disable iff (!reset_n)
		(!lc.run && !wr) |=> (low_count_reg == $past(low_count_reg));
	endproperty
	a_run_off: assert property (p_run_off) else $error("counted with run_enable clear");

	property p_match_wrap;
		@(posedge mclk) disable iff (!reset_n)
		(!lc.chain && low_tick && low_hit && !wr) |=> (low_count_reg == 16'h0000 && status_reg[TLC_ST_LOW]);
	endproperty
	a_match_wrap: assert property (p_match_wrap) else $error("period match did not wrap and flag");

	property p_irq;
		@(posedge mclk) disable iff (!reset_n)
		irq == |(status_reg & mask_reg);
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt level does not follow status and mask");

	function automatic logic [8:0] tlc_div_len(input logic [1:0] ps);
		case (ps)
			2'h3:    return {1'b0, TLC_DIV_256} + 9'h001;
			2'h2:    return {1'b0, TLC_DIV_64} + 9'h001;
			2'h1:    return {1'b0, TLC_DIV_8} + 9'h001;
			default: return 9'h001;
		endcase
	endfunction : tlc_div_len

	// cycles since the last tick; only trusted while source, gate and control hold still
	logic [8:0] gap_reg;
	logic       gap_ok_reg;
	logic       gap_steady;

	assign gap_steady = low_active && !lc.csrc && !lc.gate_en && !(wr && addr == TLC_OFS_CTRL);

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			gap_reg <= 9'h000;
		else if (low_tick)
			gap_reg <= 9'h001;
		else if (gap_reg != 9'h1FF)
			gap_reg <= gap_reg + 9'h001;
	end

	// the first tick after any change only arms the check, its spacing is not defined
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			gap_ok_reg <= 1'b0;
		else if (!gap_steady)
			gap_ok_reg <= 1'b0;
		else if (low_tick)
			gap_ok_reg <= 1'b1;
	end

	property p_div_gap;
		@(posedge mclk) disable iff (!reset_n)
		(low_tick && gap_ok_reg && gap_steady) |-> (gap_reg == tlc_div_len(lc.prescale));
	endproperty
	a_div_gap: assert property (p_div_gap) else $error("prescaled tick spacing wrong");

	property p_high_alone;
		@(posedge mclk) disable iff (!reset_n)
		(!lc.chain && !high_tick && !wr) |=> $stable(high_count_reg);
	endproperty
	a_high_alone: assert property (p_high_alone) else $error("upper count moved without its own tick");
endmodule : tlc_timer

// [tlc_pkg.sv]
// package: register map, field positions and reset values of the low timer control block
package tlc_pkg;
	localparam int          TLC_ADDR_W        = 4;
	localparam logic [3:0]  TLC_OFS_CTRL      = 4'h0;
	localparam logic [3:0]  TLC_OFS_LOW_CNT   = 4'h1;
	localparam logic [3:0]  TLC_OFS_HIGH_CNT  = 4'h2;
	localparam logic [3:0]  TLC_OFS_LOW_PER   = 4'h3;
	localparam logic [3:0]  TLC_OFS_HIGH_PER  = 4'h4;
	localparam logic [3:0]  TLC_OFS_STATUS    = 4'h5;
	localparam logic [3:0]  TLC_OFS_MASK      = 4'h6;
	localparam logic [3:0]  TLC_OFS_HIGH_CTRL = 4'h7;
	localparam int          TLC_BIT_RUN       = 15;
	localparam int          TLC_BIT_IDLE_STOP = 13;
	localparam int          TLC_BIT_GATE      = 6;
	localparam int          TLC_BIT_PS_HI     = 5;
	localparam int          TLC_BIT_PS_LO     = 4;
	localparam int          TLC_BIT_CHAIN     = 3;
	localparam int          TLC_BIT_CSRC      = 1;
	localparam logic [15:0] TLC_CTRL_WMASK    = 16'hA07A;
	localparam logic [15:0] TLC_HCTRL_WMASK   = 16'hA072;
	localparam logic [15:0] TLC_CTRL_RESET    = 16'h0000;
	localparam logic [15:0] TLC_PER_RESET     = 16'hFFFF;
	localparam int          TLC_ST_LOW        = 0;
	localparam int          TLC_ST_HIGH       = 1;
	localparam logic [7:0]  TLC_DIV_8         = 8'h07;
	localparam logic [7:0]  TLC_DIV_64        = 8'h3F;
	localparam logic [7:0]  TLC_DIV_256       = 8'hFF;

	typedef struct packed {
		logic        run;
		logic        idle_stop;
		logic        gate_en;
		logic [1:0]  prescale;
		logic        chain;
		logic        csrc;
	} tlc_ctrl_t;

	function automatic tlc_ctrl_t tlc_decode(input logic [15:0] r);
		tlc_ctrl_t c;
		c.run       = r[TLC_BIT_RUN];
		c.idle_stop = r[TLC_BIT_IDLE_STOP];
		c.gate_en   = r[TLC_BIT_GATE];
		c.prescale  = r[TLC_BIT_PS_HI:TLC_BIT_PS_LO];
		c.chain     = r[TLC_BIT_CHAIN];
		c.csrc      = r[TLC_BIT_CSRC];
		return c;
	endfunction : tlc_decode
endpackage : tlc_pkg

// [tlc_sync.sv]
// two-flop synchroniser with rising-edge pulse taken from the second stage
`timescale 1ns/10ps
module tlc_sync (
	input  wire logic mclk,
	input  wire logic reset_n,
	input  wire logic din,
	output logic      level,
	output logic      rise
);
	logic meta_reg;
	logic sync_reg;
	logic last_reg;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			last_reg <= 1'b0;
		end else begin
			meta_reg <= din;
			sync_reg <= meta_reg;
			last_reg <= sync_reg;
		end
	end

	assign level = sync_reg;
	assign rise  = sync_reg & ~last_reg;
endmodule : tlc_sync

// [tlc_prescale.sv]
// input prescaler: one tick out per 1, 8, 64 or 256 ticks in
`timescale 1ns/10ps
module tlc_prescale
	import tlc_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       reset_n,
	input  wire logic       clear,
	input  wire logic       tick_in,
	input  wire logic [1:0] sel,
	output logic            tick_out
);
	logic [7:0] div_reg;
	logic [7:0] limit;

	always_comb begin
		case (sel)
			2'h3:    limit = TLC_DIV_256;
			2'h2:    limit = TLC_DIV_64;
			2'h1:    limit = TLC_DIV_8;
			default: limit = 8'h00;
		endcase
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			div_reg <= 8'h00;
		else if (clear)
			div_reg <= 8'h00;
		else if (tick_in)
			div_reg <= (div_reg >= limit) ? 8'h00 : div_reg + 8'h01;
	end

	assign tick_out = tick_in && (div_reg >= limit);
endmodule : tlc_prescale

// [tlc_pin_model.sv]
// far-side model of the external count pin: bursts of clean rising edges
`timescale 1ns/10ps
module tlc_pin_model #(
	parameter int HALF = 3
) (
	input  wire logic       mclk,
	input  wire logic       start,
	input  wire logic [4:0] edges,
	output logic            pin,
	output logic            busy
);
	initial begin
		pin  = 1'b0;
		busy = 1'b0;
		forever begin
			@(posedge mclk);
			if (start) begin
				busy <= 1'b1;
				repeat (edges) begin
					// each level is held over two samples or more so the synchroniser never misses an edge
					pin <= 1'b1;
					repeat (HALF) @(posedge mclk);
					pin <= 1'b0;
					repeat (HALF) @(posedge mclk);
				end
				busy <= 1'b0;
			end
		end
	end
endmodule : tlc_pin_model

// [tlc_timer_test.sv]
// self-checking testbench of the low timer: registers, prescaler, gate, idle, external pin, chaining
`timescale 1ns/10ps
module tlc_timer_test;
	import tlc_pkg::*;
	logic        mclk, reset_n, idle_mode, gate_in, ext_pin, high_gate_in;
	logic [3:0]  addr;
	logic [15:0] wdata, rdata, d;
	logic        wr, rd, irq, low_match, high_match, start, busy;
	logic [4:0]  edges;
	logic [31:0] seed;
	int          fail_count, n_checks, n, lm_cnt, k;

	tlc_timer u_tlc_timer (.mclk(mclk), .reset_n(reset_n), .idle_mode(idle_mode), .gate_in(gate_in),
		.ext_count_pin(ext_pin), .high_gate_in(high_gate_in), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .irq(irq), .low_match(low_match), .high_match(high_match));
	tlc_pin_model u_tlc_pin_model (.mclk(mclk), .start(start), .edges(edges), .pin(ext_pin), .busy(busy));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	always @(posedge mclk) if (low_match === 1'b1) lm_cnt++;

	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction : xs

	// expected cycles between period matches for an internal clock
	function automatic int period_cycles(input logic [1:0] ps, input int per);
		int div;
		div = (ps == 2'h3) ? 256 : (ps == 2'h2) ? 64 : (ps == 2'h1) ? 8 : 1;
		return (per + 1) * div;
	endfunction : period_cycles

	task automatic complete_run();
		if (fail_count == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : complete_run

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			fail_count++;
		end
	endtask : check

	task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
		@(posedge mclk);
		addr  <= a;
		wdata <= v;
		wr    <= 1'b1;
		@(posedge mclk);
		wr    <= 1'b0;
	endtask : wr_reg

	task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
		@(posedge mclk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge mclk);
		rd   <= 1'b0;
		#1 v = rdata;
	endtask : rd_reg

	// cycles until the next match pulse; a lost pulse ends the run
	task automatic wait_pulse(input logic hi, output int cnt);
		cnt = 0;
		do begin
			@(posedge mclk);
			cnt++;
			if (cnt > 3000) begin
				fail_count++;
				complete_run();
			end
		end while (((hi ? high_match : low_match) !== 1'b1));
	endtask : wait_pulse

	task automatic restart(input logic [15:0] ctrl, input logic [15:0] per);
		wr_reg(TLC_OFS_CTRL, 16'h0000);
		wr_reg(TLC_OFS_LOW_CNT, 16'h0000);
		wr_reg(TLC_OFS_LOW_PER, per);
		wr_reg(TLC_OFS_CTRL, ctrl);
	endtask : restart

	initial begin
		{idle_mode, gate_in, high_gate_in, wr, rd, start} = '0;
		addr = 4'h0;
		wdata = 16'h0000;
		edges = 5'h00;
		fail_count = 0;
		n_checks = 0;
		lm_cnt = 0;
		seed = 32'hAAFE;
		reset_n = 1'b0;
		repeat (12) @(posedge mclk);
		reset_n <= 1'b1;
		rd_reg(TLC_OFS_CTRL, d);     check(d, TLC_CTRL_RESET);
		rd_reg(TLC_OFS_LOW_PER, d);  check(d, TLC_PER_RESET);
		rd_reg(4'hC, d);             check(d, 16'h0000);
		wr_reg(TLC_OFS_CTRL, 16'h7FFF);
		rd_reg(TLC_OFS_CTRL, d);     check(d, 16'h207A);
		// prescale codes with idle asserted but stop-in-idle clear, so counting must continue
		idle_mode <= 1'b1;
		for (int ps = 0; ps < 4; ps++) begin
			seed = xs(seed);
			k = (ps == 3) ? 1 : 1 + int'(seed[2:0]);
			restart(16'h8000 | 16'(ps << TLC_BIT_PS_LO), 16'(k));
			wait_pulse(1'b0, n);
			wait_pulse(1'b0, n);
			check(16'(n), 16'(period_cycles(2'(ps), k)));
		end
		// stop-in-idle halts the count
		restart(16'hA000, 16'hFFFF);
		repeat (30) @(posedge mclk);
		rd_reg(TLC_OFS_LOW_CNT, d);  check(d, 16'h0000);
		idle_mode <= 1'b0;
		// gate low blocks counting, gate high counts every cycle
		restart(16'h8040, 16'h0005);
		repeat (30) @(posedge mclk);
		rd_reg(TLC_OFS_LOW_CNT, d);  check(d, 16'h0000);
		gate_in <= 1'b1;
		wait_pulse(1'b0, n);
		wait_pulse(1'b0, n);
		check(16'(n), 16'd6);
		// external edges counted with gate low and gate enabled, which must be ignored
		gate_in <= 1'b0;
		seed = xs(seed);
		restart(16'h8042, 16'hFFFF);
		@(posedge mclk);
		edges <= 5'(1 + seed[3:0]);
		start <= 1'b1;
		@(posedge mclk);
		start <= 1'b0;
		repeat (2) @(posedge mclk);
		for (k = 0; k < 300 && busy === 1'b1; k++) @(posedge mclk);
		if (k >= 300) begin
			fail_count++;
			complete_run();
		end
		repeat (8) @(posedge mclk);
		rd_reg(TLC_OFS_LOW_CNT, d);  check(d, 16'(1 + seed[3:0]));
		// chained: 32-bit period 0000_0003, match flagged on the upper timer only
		wr_reg(TLC_OFS_HIGH_PER, 16'h0000);
		wr_reg(TLC_OFS_HIGH_CNT, 16'h0000);
		restart(16'h8008, 16'h0003);
		wait_pulse(1'b1, n);
		k = lm_cnt;
		wait_pulse(1'b1, n);
		check(16'(n), 16'd4);
		check(16'(lm_cnt), 16'(k));
		wr_reg(TLC_OFS_CTRL, 16'h0008);
		wr_reg(TLC_OFS_STATUS, 16'h0001);
		rd_reg(TLC_OFS_STATUS, d);   check(d, 16'h0002);
		check({15'h0, irq}, 16'h0000);
		wr_reg(TLC_OFS_MASK, 16'h0002);
		repeat (2) @(posedge mclk);
		#1 check({15'h0, irq}, 16'h0001);
		wr_reg(TLC_OFS_STATUS, 16'h0002);
		repeat (2) @(posedge mclk);
		#1 check({15'h0, irq}, 16'h0000);
		// carry from the low word into the high word
		wr_reg(TLC_OFS_HIGH_PER, 16'hFFFF);
		wr_reg(TLC_OFS_LOW_PER, 16'hFFFF);
		wr_reg(TLC_OFS_LOW_CNT, 16'hFFFE);
		wr_reg(TLC_OFS_CTRL, 16'h8008);
		repeat (6) @(posedge mclk);
		wr_reg(TLC_OFS_CTRL, 16'h0008);
		rd_reg(TLC_OFS_HIGH_CNT, d); check(d, 16'h0001);
		rd_reg(TLC_OFS_LOW_CNT, d);  check({d[15:4], 4'h0}, 16'h0000);
		rd_reg(TLC_OFS_LOW_CNT, n[15:0]); check(16'(n), d);
		// chaining off: the upper timer runs alone on its own control and period
		wr_reg(TLC_OFS_CTRL, 16'h0000);
		wr_reg(TLC_OFS_HIGH_CNT, 16'h0000);
		wr_reg(TLC_OFS_HIGH_PER, 16'h0002);
		wr_reg(TLC_OFS_HIGH_CTRL, 16'h8000);
		wait_pulse(1'b1, n);
		wait_pulse(1'b1, n);
		check(16'(n), 16'd3);
		complete_run();
	end
endmodule : tlc_timer_test
